/* File: include/timer18_pkg.sv */
// Purpose: Shared constants for the 18-bit timer control block.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are word indices.
package timer18_pkg;
    // ----------------
    // Register map
    // ----------------
    localparam logic [7:0] IDX_CTRL_ONE = 8'h14;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h15;
    localparam logic [7:0] IDX_COMPARE = 8'h16;
    localparam logic [7:0] IDX_PERIOD = 8'h17;
    localparam logic [7:0] IDX_STATUS = 8'h18;
    localparam logic [7:0] IDX_POWER = 8'h19;
    localparam logic [7:0] RESET_CTRL_ONE = 8'h88;
    localparam logic [7:0] RESET_CTRL_TWO = 8'h00;
    localparam logic [7:0] RESET_PERIOD = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------
    // Fields and encodings
    // ----------------
    localparam int CLR_BIT = 7;
    localparam int RUN_HI = 6;
    localparam int RUN_LO = 5;
    localparam int SRC_HI = 4;
    localparam int SRC_LO = 2;
    localparam int MODE_HI = 1;
    localparam int MODE_LO = 0;
    localparam int EDGE_BIT = 7;
    localparam int GSRC_HI = 6;
    localparam int GSRC_LO = 5;
    localparam int GIRQ_BIT = 4;
    localparam int GBASE_HI = 3;
    localparam int GBASE_LO = 2;
    localparam int ROUTE_BIT = 1;
    localparam logic [1:0] RUN_STOP = 2'h0;
    localparam logic [1:0] RUN_START = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_PULSE = 2'h2;
    localparam logic [1:0] MODE_FREQ = 2'h3;
    localparam logic [2:0] SRC_FAST = 3'h0;
    localparam logic [2:0] SRC_SLOW = 3'h1;
    localparam logic [2:0] SRC_D23 = 3'h2;
    localparam logic [2:0] SRC_D13 = 3'h3;
    localparam logic [2:0] SRC_D11 = 3'h4;
    localparam logic [2:0] SRC_D7 = 3'h5;
    localparam logic [2:0] SRC_D3 = 3'h6;
    localparam logic [1:0] GSRC_EXT = 2'h0;
    localparam logic [1:0] GSRC_INT = 2'h1;
    localparam logic [1:0] GSRC_NBR = 2'h2;
    localparam logic [1:0] GBASE_RSVD = 2'h3;
    localparam logic [4:0] GATE_SPAN = 5'h10;
    localparam logic [17:0] COUNT_MAX = 18'h3FFFF;
    localparam logic [17:0] COUNT_ONE = 18'h00001;
    localparam logic [1:0] HIGH_MASK = 2'h3;
    // Divider taps into the free-running fast and slow prescalers.
    localparam int FTAP_23 = 22;
    localparam int FTAP_14 = 13;
    localparam int FTAP_13 = 12;
    localparam int FTAP_12 = 11;
    localparam int FTAP_11 = 10;
    localparam int FTAP_7 = 6;
    localparam int FTAP_3 = 2;
    localparam int STAP_15 = 14;
    localparam int STAP_6 = 5;
    localparam int STAP_5 = 4;
    localparam int STAP_4 = 3;
    localparam int STAP_3 = 2;
    localparam int FDIV_W = 23;
    localparam int SDIV_W = 15;
endpackage

/* File: hdl/timer18_control_and_gate.sv */
// Purpose: Control registers, counter core and window gate of an 18-bit timer.
// Assumes: fast_clock is clk; slowTick marks slow clock edges synchronously.
// Notes: Registers sit at index times four.
`timescale 1ns/1ns
// Operation
// [R01] Two 8-bit controls, 18-bit compare/count and 8-bit gate period register.
// [R02] Writing 0 to clear bit clears counter and overflow; bit returns to 1; a wrap in the same cycle keeps overflow set.
// [R03] Run 00 stops and clears; 10 runs; low bit 1 reserved.
// [R04] Three-bit source select; divider or slow mode swaps three taps to slow.
// [R05] Mode: 00 timer/event, 01 reserved, 10 pulse width, 11 frequency.
// [R06] Low or middle compare byte write blocks matching until high byte write.
// [R07] Software changes mode, source, edges only while stopped.
// [R08] Undivided fast source only in slow timer or normal pulse width mode.
// [R09] Compare reads return live counter value.
// [R10] Software programs compare with one or greater.
// [R11] Timer and pulse modes use internal clock; event mode uses external.
// [R12] Software avoids fc/2^7 and fc/2^3 in slow or sleep modes.
// [R13] Compare high byte bits 7 to 2 read zero and ignore ones.
// [R14] Edge select 0 counts falling edges, 1 counts both edges.
// [R15] Gate source select picks external, internal generator or neighbour output.
// [R16] Gate interrupt on falling edge, or on both edges when set.
// [R17] Gate base unit 2^12, 2^13, 2^14 fast or 2^4..2^6 slow; 11 reserved.
// [R18] Gate high 16 minus high field units, low 16 minus low field units.
// [R19] Route bit 0 drives neighbour output to shared pin, 1 does not.
// [R20] Software writes 0 to bit 0 of second control register.
// [R21] Software uses falling-only counting in event and pulse modes.
// [R22] Reset: control one 1000 1000, control two 0000 000x.
// [R23] Timer/event compare match raises interrupt and clears counter.
// [R24] Wrap from 3FFFF to 0 sets overflow until counter clear.
// [R25] Gate select 00 uses external input itself as gate.
module timer18_control_and_gate
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer side
    input wire logic slowTick,
    input wire logic externalCountInput,
    input wire logic neighbourTimerOutput,
    output logic counterInterrupt,
    output logic sharedPortPin,
    output logic sharedPortPinOe
);
    typedef struct packed {
        logic awHeld;
        logic wHeld;
        logic [7:0] awIdx;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [7:0] ctrlOne;
        logic [7:0] ctrlTwo;
        logic [17:0] compareVal;
        logic [7:0] period;
        logic powerSlow;
        logic dividerSel;
        logic matchBlocked;
        logic [17:0] count;
        logic overflow;
        logic [22:0] fastDiv;
        logic [14:0] slowDiv;
        logic srcPrev;
        logic extPrev;
        logic gatePrev;
        logic intGate;
        logic [3:0] gateUnits;
        logic [3:0] lowLatch;
        logic baseLast;
        logic irq;
        logic pin;
        logic pinOe;
    } state_type;

    state_type cur_r;
    state_type cur_nxt;

    logic [1:0] runCtl;
    logic [2:0] srcSel;
    logic [1:0] modeSel;
    logic slowBase;
    logic srcLevel;
    logic baseLevel;
    logic gate;
    logic tick;
    logic extEdge;
    logic gateFall;
    logic gateRise;
    logic [17:0] countInc;
    logic wrFire;
    logic [31:0] wd;
    logic [17:0] cmpNew;
    logic [3:0] span;

    always_comb
    begin
        cur_nxt = cur_r;
        runCtl = cur_r.ctrlOne[timer18_pkg::RUN_HI:timer18_pkg::RUN_LO];
        srcSel = cur_r.ctrlOne[timer18_pkg::SRC_HI:timer18_pkg::SRC_LO];
        modeSel = cur_r.ctrlOne[timer18_pkg::MODE_HI:timer18_pkg::MODE_LO];
        slowBase = cur_r.dividerSel | cur_r.powerSlow;
        wd = cur_r.wData;
        cmpNew = cur_r.compareVal;
        span = 4'h0;
        // ----------------
        // Prescalers
        // ----------------
        cur_nxt.fastDiv = cur_r.fastDiv + 23'h000001;
        if (slowTick)
        begin
            cur_nxt.slowDiv = cur_r.slowDiv + 15'h0001;
        end
        // Source clock as a level; counting happens on its falling edge.
        case (srcSel)
            timer18_pkg::SRC_FAST: srcLevel = ~cur_r.srcPrev;
            timer18_pkg::SRC_SLOW: srcLevel = slowTick;
            timer18_pkg::SRC_D23: srcLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_15]
                                                      : cur_r.fastDiv[timer18_pkg::FTAP_23]; // [R04]
            timer18_pkg::SRC_D13: srcLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_5]
                                                      : cur_r.fastDiv[timer18_pkg::FTAP_13]; // [R04]
            timer18_pkg::SRC_D11: srcLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_3]
                                                      : cur_r.fastDiv[timer18_pkg::FTAP_11]; // [R04]
            timer18_pkg::SRC_D7: srcLevel = cur_r.fastDiv[timer18_pkg::FTAP_7];
            timer18_pkg::SRC_D3: srcLevel = cur_r.fastDiv[timer18_pkg::FTAP_3];
            default: srcLevel = externalCountInput; // [R04]
        endcase
        cur_nxt.srcPrev = srcLevel;
        // Gate base unit, held at zero when reserved so the generator freezes.
        case (cur_r.ctrlTwo[timer18_pkg::GBASE_HI:timer18_pkg::GBASE_LO])
            2'h0: baseLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_4]
                                       : cur_r.fastDiv[timer18_pkg::FTAP_12]; // [R17]
            2'h1: baseLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_5]
                                       : cur_r.fastDiv[timer18_pkg::FTAP_13]; // [R17]
            2'h2: baseLevel = slowBase ? cur_r.slowDiv[timer18_pkg::STAP_6]
                                       : cur_r.fastDiv[timer18_pkg::FTAP_14]; // [R17]
            default: baseLevel = 1'b0; // [R17]
        endcase
        cur_nxt.baseLast = baseLevel;
        // ----------------
        // Internal window gate generator
        // ----------------
        if (runCtl != timer18_pkg::RUN_START)
        begin
            cur_nxt.intGate = 1'b1;
            cur_nxt.gateUnits = 4'h0;
            cur_nxt.lowLatch = cur_r.period[3:0];
        end
        else if (cur_r.baseLast & ~baseLevel)
        begin
            span = cur_r.intGate ? cur_r.period[7:4] : cur_r.lowLatch;
            // Each phase lasts 16 minus its field, counted in base units.
            if (cur_r.gateUnits == 4'(timer18_pkg::GATE_SPAN - {1'b0, span} - 5'h01)) // [R18]
            begin
                cur_nxt.gateUnits = 4'h0;
                cur_nxt.intGate = ~cur_r.intGate; // [R18]
                cur_nxt.lowLatch = cur_r.period[3:0];
            end
            else
            begin
                cur_nxt.gateUnits = cur_r.gateUnits + 4'h1;
            end
        end
        case (cur_r.ctrlTwo[timer18_pkg::GSRC_HI:timer18_pkg::GSRC_LO])
            timer18_pkg::GSRC_EXT: gate = externalCountInput; // [R25]
            timer18_pkg::GSRC_INT: gate = cur_r.intGate; // [R15]
            timer18_pkg::GSRC_NBR: gate = neighbourTimerOutput; // [R15]
            default: gate = 1'b0;
        endcase
        cur_nxt.gatePrev = gate;
        cur_nxt.extPrev = externalCountInput;
        gateFall = cur_r.gatePrev & ~gate;
        gateRise = ~cur_r.gatePrev & gate;
        extEdge = cur_r.ctrlTwo[timer18_pkg::EDGE_BIT] ? (cur_r.extPrev ^ externalCountInput)
                                                       : (cur_r.extPrev & ~externalCountInput); // [R14]
        // ----------------
        // Counter core
        // ----------------
        case (modeSel)
            timer18_pkg::MODE_TIMER: tick = (srcSel == 3'h7) ? extEdge
                                                             : (cur_r.srcPrev & ~srcLevel); // [R05]
            timer18_pkg::MODE_PULSE: tick = cur_r.srcPrev & cur_r.gatePrev & ~(srcLevel & gate); // [R05]
            timer18_pkg::MODE_FREQ: tick = extEdge & gate; // [R05]
            default: tick = 1'b0; // [R05]
        endcase
        cur_nxt.irq = 1'b0;
        countInc = cur_r.count + timer18_pkg::COUNT_ONE;
        if (runCtl == timer18_pkg::RUN_START) // [R03]
        begin
            if (modeSel == timer18_pkg::MODE_TIMER && !cur_r.matchBlocked
                && cur_r.count == cur_r.compareVal && cur_r.count != 18'h0)
            begin
                cur_nxt.irq = 1'b1; // [R23]
                cur_nxt.count = 18'h0; // [R23]
            end
            else if (tick)
            begin
                cur_nxt.count = countInc;
                if (cur_r.count == timer18_pkg::COUNT_MAX)
                begin
                    cur_nxt.overflow = 1'b1; // [R24]
                end
            end
            if (modeSel[1] && (gateFall || (cur_r.ctrlTwo[timer18_pkg::GIRQ_BIT] && gateRise)))
            begin
                cur_nxt.irq = 1'b1; // [R16]
            end
        end
        else if (runCtl == timer18_pkg::RUN_STOP)
        begin
            cur_nxt.count = 18'h0; // [R03]
            cur_nxt.overflow = 1'b0; // [R03]
        end
        // ----------------
        // Register writes
        // ----------------
        wrFire = cur_r.awHeld & cur_r.wHeld & ~cur_r.bValid;
        if (s_axi_awvalid && !cur_r.awHeld)
        begin
            cur_nxt.awHeld = 1'b1;
            cur_nxt.awIdx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !cur_r.wHeld)
        begin
            cur_nxt.wHeld = 1'b1;
            cur_nxt.wData = s_axi_wdata;
            cur_nxt.wStrb = s_axi_wstrb;
        end
        if (wrFire)
        begin
            cur_nxt.awHeld = 1'b0;
            cur_nxt.wHeld = 1'b0;
            cur_nxt.bValid = 1'b1;
            cur_nxt.bResp = timer18_pkg::RESP_OKAY;
            if (cur_r.awIdx == timer18_pkg::IDX_CTRL_ONE)
            begin
                if (cur_r.wStrb[0])
                begin
                    cur_nxt.ctrlOne = wd[7:0] | (8'h01 << timer18_pkg::CLR_BIT); // [R02]
                    if (!wd[timer18_pkg::CLR_BIT])
                    begin
                        cur_nxt.count = 18'h0; // [R02]
                        cur_nxt.overflow = cur_nxt.overflow & tick & (countInc == 18'h0); // [R02]
                    end
                end
            end
            else if (cur_r.awIdx == timer18_pkg::IDX_CTRL_TWO)
            begin
                if (cur_r.wStrb[0])
                begin
                    cur_nxt.ctrlTwo = wd[7:0];
                end
            end
            else if (cur_r.awIdx == timer18_pkg::IDX_COMPARE)
            begin
                if (cur_r.wStrb[0])
                begin
                    cmpNew[7:0] = wd[7:0];
                end
                if (cur_r.wStrb[1])
                begin
                    cmpNew[15:8] = wd[15:8];
                end
                if (cur_r.wStrb[2])
                begin
                    cmpNew[17:16] = wd[17:16] & timer18_pkg::HIGH_MASK; // [R13]
                end
                cur_nxt.compareVal = cmpNew;
                // High byte completes the value; partial writes hold matching off.
                cur_nxt.matchBlocked = ~cur_r.wStrb[2] & (cur_r.matchBlocked
                                       | (|cur_r.wStrb[1:0])); // [R06]
            end
            else if (cur_r.awIdx == timer18_pkg::IDX_PERIOD)
            begin
                if (cur_r.wStrb[0])
                begin
                    cur_nxt.period = wd[7:0]; // [R01]
                end
            end
            else if (cur_r.awIdx == timer18_pkg::IDX_POWER)
            begin
                if (cur_r.wStrb[0])
                begin
                    cur_nxt.powerSlow = wd[0];
                    cur_nxt.dividerSel = wd[1];
                end
            end
            else if (cur_r.awIdx != timer18_pkg::IDX_STATUS)
            begin
                cur_nxt.bResp = timer18_pkg::RESP_SLVERR;
            end
        end
        if (cur_r.bValid && s_axi_bready)
        begin
            cur_nxt.bValid = 1'b0;
        end
        // ----------------
        // Register reads
        // ----------------
        if (cur_r.rValid && s_axi_rready)
        begin
            cur_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && !cur_r.rValid)
        begin
            cur_nxt.rValid = 1'b1;
            cur_nxt.rResp = timer18_pkg::RESP_OKAY;
            cur_nxt.rData = 32'h0;
            if (s_axi_araddr[9:2] == timer18_pkg::IDX_CTRL_ONE)
            begin
                cur_nxt.rData = {24'h0, cur_r.ctrlOne};
            end
            else if (s_axi_araddr[9:2] == timer18_pkg::IDX_CTRL_TWO)
            begin
                cur_nxt.rData = {24'h0, cur_r.ctrlTwo};
            end
            else if (s_axi_araddr[9:2] == timer18_pkg::IDX_COMPARE)
            begin
                cur_nxt.rData = {14'h0, cur_r.count}; // [R09]
            end
            else if (s_axi_araddr[9:2] == timer18_pkg::IDX_PERIOD)
            begin
                cur_nxt.rData = {24'h0, cur_r.period};
            end
            else if (s_axi_araddr[9:2] == timer18_pkg::IDX_STATUS)
            begin
                cur_nxt.rData = {30'h0, gate, cur_r.overflow};
            end
            else if (s_axi_araddr[9:2] == timer18_pkg::IDX_POWER)
            begin
                cur_nxt.rData = {30'h0, cur_r.dividerSel, cur_r.powerSlow};
            end
            else
            begin
                cur_nxt.rResp = timer18_pkg::RESP_SLVERR;
            end
        end
        // ----------------
        // Pin routing
        // ----------------
        cur_nxt.pin = neighbourTimerOutput;
        cur_nxt.pinOe = ~cur_r.ctrlTwo[timer18_pkg::ROUTE_BIT]; // [R19]
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_r <= '0;
            cur_r.ctrlOne <= timer18_pkg::RESET_CTRL_ONE; // [R22]
            cur_r.ctrlTwo <= timer18_pkg::RESET_CTRL_TWO; // [R22]
            cur_r.period <= timer18_pkg::RESET_PERIOD;
            cur_r.intGate <= 1'b1;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    assign s_axi_awready = ~cur_r.awHeld;
    assign s_axi_wready = ~cur_r.wHeld;
    assign s_axi_bvalid = cur_r.bValid;
    assign s_axi_bresp = cur_r.bResp;
    assign s_axi_arready = ~cur_r.rValid;
    assign s_axi_rvalid = cur_r.rValid;
    assign s_axi_rdata = cur_r.rData;
    assign s_axi_rresp = cur_r.rResp;
    assign counterInterrupt = cur_r.irq;
    assign sharedPortPin = cur_r.pin;
    assign sharedPortPinOe = cur_r.pinOe;
endmodule

/* File: tb/timer18_chk.sv */
// Purpose: Bus and output checks for the timer block.
// Assumes: One clock domain, reset active low.
// Notes: Sees only the top ports; attached by bind.
`timescale 1ns/1ns
module timer18_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer side
    input wire logic neighbourTimerOutput,
    input wire logic counterInterrupt,
    input wire logic sharedPortPin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------
    // Handshake steps
    // ----------------
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read answer");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data kept");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar taken while busy");
    wr_answer_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    aw_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("aw taken twice");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response kept");
    irq_pulse_a: assert property (counterInterrupt |=> !counterInterrupt)
        else $error("long interrupt");
    pin_copy_a: assert property ($past(rst_n) |-> sharedPortPin == $past(neighbourTimerOutput))
        else $error("pin not following");
endmodule
bind timer18_control_and_gate timer18_chk timer18_chk_i
(
    .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .neighbourTimerOutput, .counterInterrupt, .sharedPortPin
);

/* File: tb/external_count_input_source.sv */
// Purpose: Event source and neighbour output model.
// Assumes: The bench asks for a number of pulses at a time.
// Notes: Pulses are two cycles high, two low.
`timescale 1ns/1ns
module event_source
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic [7:0] pulseCount,
    input wire logic pulseGo,
    output logic pulseBusy,
    // Lines into the timer
    output logic externalCountInput,
    output logic neighbourTimerOutput
);
    logic [7:0] left_r;
    logic [2:0] phase_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_r <= 8'h00;
            phase_r <= 3'h0;
        end
        else if (pulseGo)
        begin
            left_r <= pulseCount;
            phase_r <= 3'h0;
        end
        else
        begin
            phase_r <= phase_r + 3'h1;
            if (left_r != 8'h00 && phase_r[1:0] == 2'h3)
                left_r <= left_r - 8'h01;
        end
    end
    // Idle low between bursts, so the first rise is a real edge.
    assign externalCountInput = (left_r != 8'h00) && !phase_r[1];
    assign pulseBusy = left_r != 8'h00;
    assign neighbourTimerOutput = phase_r[2];
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the timer block.
// Assumes: Byte address is index times four.
// Notes: Overflow needs 2^18 counts, too long for this run; it is left unchecked.
`timescale 1ns/1ns
module testbench;
    localparam logic [9:0] A1 = {timer18_pkg::IDX_CTRL_ONE, 2'h0};
    localparam logic [9:0] A2 = {timer18_pkg::IDX_CTRL_TWO, 2'h0};
    localparam logic [9:0] AC = {timer18_pkg::IDX_COMPARE, 2'h0};
    localparam logic [9:0] AP = {timer18_pkg::IDX_PERIOD, 2'h0};
    logic clk, rst_n, slowTick, externalCountInput, neighbourTimerOutput;
    logic counterInterrupt, sharedPortPin, sharedPortPinOe, pulseGo, pulseBusy;
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] pulseCount;
    int numErrors, samplesChecked, irqs, cycles;
    timer18_control_and_gate timer18_control_and_gate_i
    (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slowTick, .externalCountInput,
        .neighbourTimerOutput, .counterInterrupt, .sharedPortPin, .sharedPortPinOe
    );
    event_source event_source_i
    (
        .clk, .rst_n, .pulseCount, .pulseGo, .pulseBusy, .externalCountInput,
        .neighbourTimerOutput
    );
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        irqs <= irqs + (counterInterrupt === 1'b1 ? 1 : 0);
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            numErrors++;
            conclude;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        logic done;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [9:0] a);
        logic done;
        done = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                rdat = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    task automatic pulses(input logic [7:0] n);
        @(posedge clk);
        pulseCount <= n;
        pulseGo <= 1'b1;
        @(posedge clk);
        pulseGo <= 1'b0;
        @(posedge clk);
        while (pulseBusy)
            @(posedge clk);
    endtask
    task automatic t_fields;
        rd(A1);
        chk(rdat, 32'h00000088);
        rd(A2);
        chk(rdat, 32'h00000000);
        wr(A1, 32'h00000008, 4'hF);
        rd(A1);
        chk(rdat, 32'h00000088);
        for (int i = 0; i < 32; i++)
        begin
            wr(A1, 32'h80 | 32'(i), 4'hF);
            rd(A1);
            chk(rdat, 32'h80 | 32'(i));
        end
        for (int i = 0; i < 256; i += 2)
        begin
            wr(A2, 32'(i), 4'hF);
            rd(A2);
            chk(rdat, 32'(i));
        end
        wr(AP, 32'h000000A5, 4'hF);
        rd(AP);
        chk(rdat, 32'h000000A5);
        rd(10'h3FC);
        chk({rdat[29:0], resp}, {30'h0, timer18_pkg::RESP_SLVERR});
    endtask
    task automatic t_event;
        wr(A2, 32'h0, 4'hF);
        wr(A1, 32'h9C, 4'hF);
        wr(AC, 32'hFFFFFFFF, 4'hF);
        wr(A1, 32'h000000DC, 4'hF);
        pulses(8'h05);
        rd(AC);
        chk(rdat, 32'h00000005);
        wr(A1, 32'h0000009C, 4'hF);
        rd(AC);
        chk(rdat, 32'h00000000);
        wr(A2, 32'h00000080, 4'hF);
        wr(A1, 32'h000000DC, 4'hF);
        pulses(8'h03);
        rd(AC);
        chk(rdat, 32'h00000006);
    endtask
    task automatic t_match(input logic [31:0] cmp, input logic [3:0] strb, input logic [31:0] c);
        int base;
        wr(A1, 32'h0000009C, 4'hF);
        wr(A2, 32'h00000000, 4'hF);
        wr(AC, 32'h00000002, 4'hF);
        wr(AC, cmp, strb);
        base = irqs;
        wr(A1, 32'h000000DC, 4'hF);
        pulses(c[7:0]);
        rd(AC);
        chk(rdat, cmp == 32'h3 ? 32'h0 : c);
        chk(32'(irqs - base), cmp == 32'h3 ? 32'h1 : 32'h0);
    endtask
    task automatic t_route;
        wr(A2, 32'h00000002, 4'hF);
        @(posedge clk);
        chk(32'(sharedPortPinOe), 32'h0);
        wr(A2, 32'h00000000, 4'hF);
        @(posedge clk);
        chk(32'(sharedPortPinOe), 32'h1);
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", numErrors, samplesChecked);
        if (numErrors == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        {rst_n, slowTick, pulseGo, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
        {s_axi_arvalid, s_axi_rready, pulseCount, s_axi_wstrb} = 14'h0000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
        {numErrors, samplesChecked, irqs, cycles} = 128'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_fields;
        t_event;
        t_match(32'h00000003, 4'hF, 32'h00000003);
        t_match(32'h00000001, 4'h1, 32'h00000002);
        t_route;
        conclude;
    end
endmodule
